// ===== bench/fbcw_plc_model.sv
// Fieldbus master model: passes command bits, toggles the liveness bit.
// Assumes the bench drives cmd_i shortly after the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module fbcw_plc_model
    import fbcw_pkg::*;
#(
    parameter int unsigned HALF = 3
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [fbcw_pkg::WORD_W-1:0] cmd_i,
    input wire logic pulse_en_i,
    output logic [fbcw_pkg::WORD_W-1:0] word_o
);
    logic pulse_reg;
    int unsigned cnt_reg;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pulse_reg <= 1'b0;
            cnt_reg <= 0;
        end else if (pulse_en_i) begin
            if (cnt_reg == HALF - 1) begin
                cnt_reg <= 0;
                pulse_reg <= ~pulse_reg;
            end else begin
                cnt_reg <= cnt_reg + 1;
            end
        end
    end

    always_comb begin
        word_o = cmd_i;
        word_o[CW_LIVE] = pulse_reg;
    end
endmodule : fbcw_plc_model
`default_nettype wire

// ===== bench/tb.sv
// Bench for the fieldbus command block: words, status and liveness.
// Assumes the design carries its own assertions.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fbcw_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [WORD_W-1:0] cmd = '0;
    logic [WORD_W-1:0] standard_command_word_i = '0;
    logic [TMO_W-1:0] liveness_timeout_param_i = '0;
    logic profile_mode_i = 1'b1;
    logic aux_inch_enable_i = 1'b0;
    logic io_inch_enable_i = 1'b0;
    logic io_control_i = 1'b0;
    logic fb_place_selected_i = 1'b0;
    logic off_cmd_i = 1'b0;
    logic pulse_en = 1'b0;
    logic [11:0] st = '0;
    wire logic ready_on_i = st[0], ready_run_i = st[1];
    wire logic running_i = st[2], flux_ready_i = st[3];
    wire logic drive_fault_i = st[4], warning_i = st[5];
    wire logic at_ref_i = st[6], above_limit_i = st[7];
    wire logic coast_cmd_i = st[8], qstop_cmd_i = st[9];
    wire logic brake_fb_used_i = st[10], brake_open_i = st[11];
    wire logic [WORD_W-1:0] profile_command_word_i;
    logic [WORD_W-1:0] profile_state_word_o;
    logic inch1_run_o, inch2_run_o, fb_cmd_valid_o, coast_stop_o;
    logic run_request_o, ccw_o, fault_reset_o, comm_fault_o;
    int failures = 0;
    int n_checks = 0;
    int pos[15] = '{0, 1, 2, 2, 2, 2, 3, 3, 7, 7, 8, 10, 4, 4, 5};
    logic [11:0] pat[15] = '{12'h001, 12'h002, 12'h00c, 12'h004,
        12'h40c, 12'hc0c, 12'h010, 12'h000, 12'h020, 12'h000,
        12'h040, 12'h080, 12'h000, 12'h100, 12'h200};
    // Expected bit per table row, row k in bit k
    logic [14:0] ex = 15'h1d67;

    fbcw_top #(.TICK_CYCLES(4)) i_fbcw_top (.ref_clk_i, .reset_i,
        .profile_command_word_i, .standard_command_word_i,
        .liveness_timeout_param_i, .profile_mode_i, .aux_inch_enable_i,
        .io_inch_enable_i, .io_control_i, .fb_place_selected_i,
        .ready_on_i, .ready_run_i, .running_i, .flux_ready_i,
        .brake_fb_used_i, .brake_open_i, .drive_fault_i, .warning_i,
        .at_ref_i, .above_limit_i, .coast_cmd_i, .qstop_cmd_i, .off_cmd_i,
        .profile_state_word_o, .inch1_run_o, .inch2_run_o, .fb_cmd_valid_o,
        .coast_stop_o, .run_request_o, .ccw_o, .fault_reset_o,
        .comm_fault_o);

    fbcw_plc_model i_fbcw_plc_model (.ref_clk_i, .reset_i, .cmd_i(cmd),
        .pulse_en_i(pulse_en), .word_o(profile_command_word_i));

    always #10 ref_clk_i = ~ref_clk_i;

    task check(input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %b want %b", $time, seen, exp);
        end
    endtask : check

    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    task report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #(20 * 3000);
        failures++;
        report_and_stop();
    end

    initial begin : main
        int k;
        int n;
        logic live;
        tick(4);
        check(profile_state_word_o === WORD_RST, 1'b1);
        tick(1);
        reset_i = 1'b0;
        for (k = 0; k < 15; k++) begin
            st = pat[k];
            tick(3);
            check(profile_state_word_o[pos[k]], ex[k]);
        end
        check(profile_state_word_o[SW_INHIBIT], 1'b1);
        st = '0;
        tick(4);
        check(profile_state_word_o[SW_INHIBIT], 1'b1);
        off_cmd_i = 1'b1;
        tick(4);
        check(profile_state_word_o[SW_INHIBIT], 1'b0);
        off_cmd_i = 1'b0;
        fb_place_selected_i = 1'b1;
        aux_inch_enable_i = 1'b1;
        st = 12'h00c;
        cmd = 16'h0500;
        tick(5);
        check(inch1_run_o, 1'b1);
        check(inch2_run_o, 1'b0);
        check(fb_cmd_valid_o, 1'b1);
        check(profile_state_word_o[SW_CTRL_REQ], 1'b1);
        cmd = 16'h0100;
        n = 0;
        repeat (6) begin
            tick(1);
            n += (coast_stop_o === 1'b1);
        end
        check(n != 0, 1'b1);
        check(inch1_run_o, 1'b0);
        check(fb_cmd_valid_o, 1'b0);
        check(profile_state_word_o[SW_CTRL_REQ], 1'b0);
        st = '0;
        aux_inch_enable_i = 1'b0;
        io_control_i = 1'b1;
        io_inch_enable_i = 1'b1;
        cmd = 16'h0600;
        tick(5);
        check(inch2_run_o, 1'b1);
        check(coast_stop_o, 1'b0);
        io_control_i = 1'b0;
        tick(5);
        check(inch2_run_o, 1'b0);
        aux_inch_enable_i = 1'b1;
        cmd = 16'h0700;
        tick(5);
        check(inch1_run_o | inch2_run_o, 1'b0);
        pulse_en = 1'b1;
        tick(4);
        pulse_en = 1'b0;
        tick(40);
        check(profile_state_word_o[SW_ECHO], 1'b1);
        check(comm_fault_o, 1'b0);
        liveness_timeout_param_i = 16'h0002;
        pulse_en = 1'b1;
        tick(77);
        // Echo lags the bus word by two sync stages and one register
        live = profile_command_word_i[CW_LIVE];
        tick(3);
        check(comm_fault_o, 1'b0);
        check(profile_state_word_o[SW_ECHO], live);
        pulse_en = 1'b0;
        tick(5);
        check(comm_fault_o, 1'b0);
        n = 0;
        repeat (40) begin
            tick(1);
            n += (comm_fault_o === 1'b1);
        end
        check(n != 0, 1'b1);
        check(profile_state_word_o[SW_INHIBIT], 1'b1);
        liveness_timeout_param_i = '0;
        profile_mode_i = 1'b0;
        standard_command_word_i = 16'hfff9;
        tick(5);
        check(run_request_o, 1'b1);
        check(ccw_o, 1'b0);
        check(fault_reset_o, 1'b0);
        check(comm_fault_o, 1'b1);
        standard_command_word_i = 16'h0002;
        tick(5);
        check(run_request_o, 1'b0);
        check(ccw_o, 1'b1);
        standard_command_word_i = 16'h0004;
        n = 0;
        repeat (8) begin
            tick(1);
            n += (fault_reset_o === 1'b1);
        end
        check(n == 1, 1'b1);
        check(comm_fault_o, 1'b0);
        profile_mode_i = 1'b1;
        standard_command_word_i = 16'h0003;
        tick(5);
        check(run_request_o | ccw_o, 1'b0);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire

// ===== hw/fbcw_live_mon.sv
// Liveness pulse supervisor: restarts on every toggle of the pulse bit.
// Assumes the pulse input is already on the control clock.
`timescale 1ns/100ps
`default_nettype none
module fbcw_live_mon
    import fbcw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic pulse_i,
    input wire logic [TMO_W-1:0] timeout_i,
    input wire logic clear_i,
    output logic fault_o
);
    logic pulse_reg;
    logic [TICK_W-1:0] tick_reg;
    logic [TMO_W-1:0] ms_reg;
    logic toggled;

    assign toggled = pulse_i != pulse_reg;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i || toggled || timeout_i == '0) begin
            tick_reg <= '0;
            ms_reg <= '0;
        end else if (tick_reg == TICK_W'(TICK_CYCLES - 1)) begin
            tick_reg <= '0;
            if (ms_reg != timeout_i) begin
                ms_reg <= ms_reg + 1'b1;
            end
        end else begin
            tick_reg <= tick_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            fault_o <= 1'b0;
        end else if (timeout_i != '0 && ms_reg == timeout_i) begin
            fault_o <= 1'b1;
        end else if (clear_i) begin
            fault_o <= 1'b0;
        end
    end

    property p_no_fault_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        (timeout_i == '0 && !fault_o) |=> !fault_o;
    endproperty
    a_no_fault_off: assert property (p_no_fault_off)
        else $error("liveness fault while supervision off");
endmodule : fbcw_live_mon
`default_nettype wire

// ===== hw/fbcw_pkg.sv
// Package: bit positions, widths and timing for the fieldbus command block.
// Assumes a 50 MHz control clock.
package fbcw_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned WORD_W = 16;
    // Profile command word bits
    localparam int unsigned CW_INCH1 = 8;
    localparam int unsigned CW_INCH2 = 9;
    localparam int unsigned CW_FB_EN = 10;
    localparam int unsigned CW_LIVE = 11;
    // Profile state word bits
    localparam int unsigned SW_RDY_ON = 0;
    localparam int unsigned SW_RDY_RUN = 1;
    localparam int unsigned SW_RUNNING = 2;
    localparam int unsigned SW_FAULT = 3;
    localparam int unsigned SW_NO_COAST = 4;
    localparam int unsigned SW_NO_QSTOP = 5;
    localparam int unsigned SW_INHIBIT = 6;
    localparam int unsigned SW_WARN = 7;
    localparam int unsigned SW_AT_REF = 8;
    localparam int unsigned SW_CTRL_REQ = 9;
    localparam int unsigned SW_ABOVE = 10;
    localparam int unsigned SW_ECHO = 15;
    // Standard command word bits
    localparam int unsigned SC_START = 0;
    localparam int unsigned SC_CCW = 1;
    localparam int unsigned SC_FRESET = 2;
    // Liveness timeout unit: one millisecond
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned TICK_W = 16;
    localparam int unsigned TMO_W = 16;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
endpackage : fbcw_pkg

// ===== hw/fbcw_top.sv
// Fieldbus command interpreter and state word builder for a crane drive.
// Assumes command words arrive from an unsynchronised fieldbus interface.
//
// Functional notes
// - Bit 8 runs toward inching setpoint one, only when inching enabled.
// - Bit 9 runs toward inching setpoint two, only when inching enabled.
// - Bit 10 clear ignores command word; clearing while running coasts.
// - Master toggles bit 11; missing pulse puts drive in fault.
// - Liveness supervised only while configured timeout is non-zero.
// - State bit 0 shows ready to switch on.
// - State bit 1 shows ready to run.
// - State bit 2: running, flux ready, brake open if feedback used.
// - State bit 3 shows fault state.
// - State bit 4 low while coasting stop commanded.
// - State bit 5 low while quick stop commanded.
// - State bit 6 set after stops or fault; cleared by OFF after release.
// - State bit 7 follows warning, no acknowledgement.
// - State bit 8 set when speed at setpoint.
// - State bit 9 set when drive requests master control.
// - State bit 10 set when speed above threshold.
// - State bit 15 echoes command bit 11.
// - Standard word bit 0 start, bit 1 counter-clockwise.
// - Standard bit 2 rising edge resets faults; bits 3 to 15 ignored.
// - Coasting stop coasts then enters switch-on inhibited.
`timescale 1ns/100ps
`default_nettype none
module fbcw_top
    import fbcw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [fbcw_pkg::WORD_W-1:0] profile_command_word_i,
    input wire logic [fbcw_pkg::WORD_W-1:0] standard_command_word_i,
    input wire logic [fbcw_pkg::TMO_W-1:0] liveness_timeout_param_i,
    input wire logic profile_mode_i,
    input wire logic aux_inch_enable_i,
    input wire logic io_inch_enable_i,
    input wire logic io_control_i,
    input wire logic fb_place_selected_i,
    input wire logic ready_on_i,
    input wire logic ready_run_i,
    input wire logic running_i,
    input wire logic flux_ready_i,
    input wire logic brake_fb_used_i,
    input wire logic brake_open_i,
    input wire logic drive_fault_i,
    input wire logic warning_i,
    input wire logic at_ref_i,
    input wire logic above_limit_i,
    input wire logic coast_cmd_i,
    input wire logic qstop_cmd_i,
    input wire logic off_cmd_i,
    output logic [fbcw_pkg::WORD_W-1:0] profile_state_word_o,
    output logic inch1_run_o,
    output logic inch2_run_o,
    output logic fb_cmd_valid_o,
    output logic coast_stop_o,
    output logic run_request_o,
    output logic ccw_o,
    output logic fault_reset_o,
    output logic comm_fault_o
);
    logic [WORD_W-1:0] pcw_s1_reg, pcw_reg;
    logic [WORD_W-1:0] scw_s1_reg, scw_reg;
    logic [2:0] pin_s1_reg, pin_reg;
    logic fb_en_d_reg;
    logic scw_rst_d_reg;
    logic inhibit_reg;
    logic released_reg;
    logic live_fault;
    logic inch_en;
    logic brake_ok;
    logic [WORD_W-1:0] state_next;

    // Two-stage synchronisers for words and pins
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pcw_s1_reg <= WORD_RST;
            pcw_reg <= WORD_RST;
            scw_s1_reg <= WORD_RST;
            scw_reg <= WORD_RST;
            pin_s1_reg <= 3'h0;
            pin_reg <= 3'h0;
        end else begin
            pcw_s1_reg <= profile_command_word_i;
            pcw_reg <= pcw_s1_reg;
            scw_s1_reg <= standard_command_word_i;
            scw_reg <= scw_s1_reg;
            pin_s1_reg <= {io_control_i, io_inch_enable_i,
                aux_inch_enable_i};
            pin_reg <= pin_s1_reg;
        end
    end

    assign inch_en = pin_reg[0] | (pin_reg[2] & pin_reg[1]);
    assign brake_ok = !brake_fb_used_i | brake_open_i;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            inch1_run_o <= 1'b0;
            inch2_run_o <= 1'b0;
        end else begin
            inch1_run_o <= profile_mode_i && pcw_reg[CW_FB_EN] && inch_en
                && pcw_reg[CW_INCH1] && !pcw_reg[CW_INCH2];
            inch2_run_o <= profile_mode_i && pcw_reg[CW_FB_EN] && inch_en
                && pcw_reg[CW_INCH2] && !pcw_reg[CW_INCH1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            fb_en_d_reg <= 1'b0;
            fb_cmd_valid_o <= 1'b0;
            coast_stop_o <= 1'b0;
        end else begin
            fb_en_d_reg <= pcw_reg[CW_FB_EN];
            fb_cmd_valid_o <= !profile_mode_i || pcw_reg[CW_FB_EN];
            if (profile_mode_i && fb_en_d_reg && !pcw_reg[CW_FB_EN]
                && running_i) begin
                coast_stop_o <= 1'b1;
            end else if (!running_i || pcw_reg[CW_FB_EN]) begin
                coast_stop_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            scw_rst_d_reg <= 1'b0;
            run_request_o <= 1'b0;
            ccw_o <= 1'b0;
            fault_reset_o <= 1'b0;
        end else begin
            scw_rst_d_reg <= scw_reg[SC_FRESET];
            run_request_o <= !profile_mode_i && scw_reg[SC_START];
            ccw_o <= !profile_mode_i && scw_reg[SC_CCW];
            fault_reset_o <= !profile_mode_i && scw_reg[SC_FRESET]
                && !scw_rst_d_reg;
        end
    end

    fbcw_live_mon #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_live (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .pulse_i(pcw_reg[CW_LIVE]),
        .timeout_i(profile_mode_i ? liveness_timeout_param_i : '0),
        .clear_i(fault_reset_o),
        .fault_o(live_fault)
    );

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            comm_fault_o <= 1'b0;
        end else begin
            comm_fault_o <= live_fault;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            inhibit_reg <= 1'b0;
            released_reg <= 1'b0;
        end else if (drive_fault_i || live_fault || coast_cmd_i
            || qstop_cmd_i || coast_stop_o) begin
            inhibit_reg <= 1'b1;
            released_reg <= 1'b0;
        end else if (inhibit_reg) begin
            released_reg <= 1'b1;
            if (released_reg && off_cmd_i) begin
                inhibit_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        state_next = '0;
        state_next[SW_RDY_ON] = ready_on_i;
        state_next[SW_RDY_RUN] = ready_run_i;
        state_next[SW_RUNNING] = running_i && flux_ready_i && brake_ok;
        state_next[SW_FAULT] = drive_fault_i || live_fault;
        state_next[SW_NO_COAST] = !coast_cmd_i;
        state_next[SW_NO_QSTOP] = !qstop_cmd_i;
        state_next[SW_INHIBIT] = inhibit_reg;
        state_next[SW_WARN] = warning_i;
        state_next[SW_AT_REF] = at_ref_i;
        state_next[SW_CTRL_REQ] = fb_place_selected_i && pcw_reg[CW_FB_EN];
        state_next[SW_ABOVE] = above_limit_i;
        state_next[SW_ECHO] = pcw_reg[CW_LIVE];
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            profile_state_word_o <= WORD_RST;
        end else begin
            profile_state_word_o <= state_next;
        end
    end

    property p_echo;
        @(posedge ref_clk_i) disable iff (reset_i)
        ##1 profile_state_word_o[SW_ECHO] == $past(pcw_reg[CW_LIVE]);
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo bit mismatch");

    property p_inch_excl;
        @(posedge ref_clk_i) disable iff (reset_i)
        !(inch1_run_o && inch2_run_o);
    endproperty
    a_inch_excl: assert property (p_inch_excl)
        else $error("both inching outputs active");

    property p_inch2_en;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!inch_en) |=> !inch2_run_o;
    endproperty
    a_inch2_en: assert property (p_inch2_en)
        else $error("inching two without enable");

    property p_fb_dis;
        @(posedge ref_clk_i) disable iff (reset_i)
        (profile_mode_i && !pcw_reg[CW_FB_EN]) |=> !fb_cmd_valid_o;
    endproperty
    a_fb_dis: assert property (p_fb_dis)
        else $error("command accepted while control disabled");

    property p_fault_bit;
        @(posedge ref_clk_i) disable iff (reset_i)
        live_fault |=> profile_state_word_o[SW_FAULT];
    endproperty
    a_fault_bit: assert property (p_fault_bit)
        else $error("liveness fault not shown");

    property p_run_bit;
        @(posedge ref_clk_i) disable iff (reset_i)
        (brake_fb_used_i && !brake_open_i) |=>
            !profile_state_word_o[SW_RUNNING];
    endproperty
    a_run_bit: assert property (p_run_bit)
        else $error("running shown with brake closed");

    property p_coast_inv;
        @(posedge ref_clk_i) disable iff (reset_i)
        coast_cmd_i |=> !profile_state_word_o[SW_NO_COAST]
            && inhibit_reg;
    endproperty
    a_coast_inv: assert property (p_coast_inv)
        else $error("coast stop not reflected");

    property p_freset;
        @(posedge ref_clk_i) disable iff (reset_i)
        fault_reset_o |-> $past(scw_reg[SC_FRESET])
            && !$past(scw_rst_d_reg);
    endproperty
    a_freset: assert property (p_freset)
        else $error("fault reset without rising edge");

    property p_inhibit_hold;
        @(posedge ref_clk_i) disable iff (reset_i)
        (inhibit_reg && !off_cmd_i) |=> inhibit_reg;
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold)
        else $error("inhibit cleared without OFF");

    property p_inch1_en;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!inch_en) |=> !inch1_run_o;
    endproperty
    a_inch1_en: assert property (p_inch1_en)
        else $error("inching one without enable");

    property p_coast_set;
        @(posedge ref_clk_i) disable iff (reset_i)
        (profile_mode_i && fb_en_d_reg && !pcw_reg[CW_FB_EN] && running_i)
            |=> coast_stop_o;
    endproperty
    a_coast_set: assert property (p_coast_set)
        else $error("no coasting stop on enable loss while running");

    property p_coast_inh;
        @(posedge ref_clk_i) disable iff (reset_i)
        coast_stop_o |=> inhibit_reg;
    endproperty
    a_coast_inh: assert property (p_coast_inh)
        else $error("coasting stop did not inhibit switch-on");

    property p_comm_flag;
        @(posedge ref_clk_i) disable iff (reset_i)
        live_fault |=> comm_fault_o;
    endproperty
    a_comm_flag: assert property (p_comm_flag)
        else $error("liveness fault not flagged");

    property p_live_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!profile_mode_i && !live_fault) |=> !live_fault;
    endproperty
    a_live_off: assert property (p_live_off)
        else $error("liveness fault raised while supervision off");

    property p_std_quiet;
        @(posedge ref_clk_i) disable iff (reset_i)
        profile_mode_i |=> !run_request_o && !ccw_o && !fault_reset_o;
    endproperty
    a_std_quiet: assert property (p_std_quiet)
        else $error("standard outputs active in profile mode");

    property p_fr_pulse;
        @(posedge ref_clk_i) disable iff (reset_i)
        fault_reset_o |=> !fault_reset_o;
    endproperty
    a_fr_pulse: assert property (p_fr_pulse)
        else $error("fault reset longer than one cycle");

    property p_warn_bit;
        @(posedge ref_clk_i) disable iff (reset_i)
        warning_i |=> profile_state_word_o[SW_WARN];
    endproperty
    a_warn_bit: assert property (p_warn_bit)
        else $error("warning not shown");

    property p_qstop_bit;
        @(posedge ref_clk_i) disable iff (reset_i)
        qstop_cmd_i |=> !profile_state_word_o[SW_NO_QSTOP];
    endproperty
    a_qstop_bit: assert property (p_qstop_bit)
        else $error("quick stop not reflected");
endmodule : fbcw_top
`default_nettype wire
